// ### tfci_pkg.sv
// Functional notes
// - write-gate readback bit is low during a write operation, high otherwise.
// - readback bits five to two are inverted head bits three to zero.
// - readback bit one is low when drive one is active and selected.
// - readback bit zero is low when drive zero is active and selected.
// - class-one command sets busy within 400 ns of the command write.
// - class two: busy within 400 ns, request within 700 us, busy drops.
// - class three: busy within 400 ns, request within 20 ms, busy drops.
// - no-operation opcode completes without any media action.
// - full drive/head parameter means drive bit and head bits both apply.
// - drive-only commands use the drive bit and ignore head bits.
// - write-without-erase: opcode CDh class three, opcode 38h class two.
// - F8h native max query uses drive only; F9h set max is full.
// - power-mode query decoded from 98h or E5h, drive bit only.
// - power query in standby loads zero count, clears busy, interrupts.
// - power query when idle loads all ones count, clears busy, interrupts.
// - sector erase has no data phase and may end with write fault.
// - status read clears pending interrupt; alternate status read does not.
// - drive bit low selects drive zero, high selects drive one.
package tfci_pkg;
  // task file offsets
  localparam logic [3:0] OFS_ERR_FEAT = 4'h1,
                         OFS_SEC_CNT  = 4'h2,
                         OFS_SEC_NUM  = 4'h3,
                         OFS_CYL_LO   = 4'h4,
                         OFS_CYL_HI   = 4'h5,
                         OFS_DRV_HEAD = 4'h6,
                         OFS_CMD_STAT = 4'h7,
                         OFS_CTL_ALT  = 4'hE,
                         OFS_DRV_ADDR = 4'hF;
  // field positions
  localparam int DH_LBA_BIT  = 6;
  localparam int DH_DRV_BIT  = 4;
  localparam int CTL_SRST    = 2;
  localparam int CTL_NIEN    = 1;
  // reset and load values
  localparam logic [7:0] SC_RESET   = 8'h01;
  localparam logic [7:0] DH_RESET   = 8'hA0;
  localparam logic [7:0] SC_STANDBY = 8'h00;
  localparam logic [7:0] SC_IDLE    = 8'hFF;
  // opcodes
  localparam logic [7:0] OP_NOP      = 8'h00,
                         OP_PWR_A    = 8'h98,
                         OP_PWR_B    = 8'hE5,
                         OP_ERASE    = 8'hC0,
                         OP_WR_MULNE = 8'hCD,
                         OP_WR_SECNE = 8'h38,
                         OP_MAX_RD   = 8'hF8,
                         OP_MAX_SET  = 8'hF9;
  // timing
  localparam int CLK_NS       = 5;
  localparam int T_BSY_NS     = 400;
  localparam int T_DRQ2_US    = 700;
  localparam int T_DRQ3_MS    = 20;
  localparam int BSY_MAX_CYC  = T_BSY_NS / CLK_NS;
  localparam int DRQ2_MAX_CYC = (T_DRQ2_US * 1000) / CLK_NS;
  localparam int DRQ3_MAX_CYC = (T_DRQ3_MS * 1000000) / CLK_NS;
  localparam int TMR_W        = 23;
  // command kinds and states
  typedef enum logic [2:0] {
    K_MEDIA = 3'h0,
    K_NOP   = 3'h1,
    K_PWRQ  = 3'h2,
    K_ERASE = 3'h3,
    K_BAD   = 3'h4
  } tfci_kind_t;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_PREP  = 3'b001,
    ST_XFER  = 3'b011,
    ST_EXEC  = 3'b010,
    ST_QUICK = 3'b100
  } tfci_state_t;
endpackage

// ### tfci_cmd_decode.sv
`timescale 1ns/100ps
`default_nettype none
module tfci_cmd_decode (
  // opcode
  input  wire logic [7:0]         opcode_i,
  // decode results
  output tfci_pkg::tfci_kind_t    kind_o,
  output logic      [1:0]         class_o,
  output logic                    dh_full_o
);
  always_comb begin
    kind_o    = tfci_pkg::K_MEDIA;
    class_o   = 2'h1;
    dh_full_o = 1'b0;
    casez (opcode_i)
      tfci_pkg::OP_NOP: begin
        kind_o = tfci_pkg::K_NOP;
      end
      tfci_pkg::OP_PWR_A, tfci_pkg::OP_PWR_B: begin
        kind_o = tfci_pkg::K_PWRQ;
      end
      tfci_pkg::OP_ERASE: begin
        kind_o    = tfci_pkg::K_ERASE;
        dh_full_o = 1'b1;
      end
      tfci_pkg::OP_WR_MULNE, 8'hC5, 8'h3C: begin
        class_o   = 2'h3;
        dh_full_o = 1'b1;
      end
      tfci_pkg::OP_WR_SECNE, 8'h30, 8'h31, 8'h50, 8'hCA: begin
        class_o   = 2'h2;
        dh_full_o = 1'b1;
      end
      8'hE8: begin
        class_o = 2'h2;
      end
      tfci_pkg::OP_MAX_SET, 8'h91, 8'hC8, 8'hC4, 8'h20, 8'h21,
      8'h40, 8'h41, 8'h7?, 8'h87, 8'hF5: begin
        dh_full_o = 1'b1;
      end
      tfci_pkg::OP_MAX_RD, 8'h90, 8'hE7, 8'hEC, 8'hE3, 8'h97,
      8'hE1, 8'h95, 8'hE4, 8'h1?, 8'h03, 8'hEF, 8'hC6, 8'hE6,
      8'h99, 8'hB0, 8'hE2, 8'h96, 8'hE0, 8'h94: begin
        dh_full_o = 1'b0;
      end
      default: begin
        kind_o = tfci_pkg::K_BAD;
      end
    endcase
  end
endmodule
`default_nettype wire

// ### tfci_core.sv
`timescale 1ns/100ps
`default_nettype none
module tfci_core #(
  parameter int DRQ2_CYC = tfci_pkg::DRQ2_MAX_CYC,
  parameter int DRQ3_CYC = tfci_pkg::DRQ3_MAX_CYC
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // task file port
  input  wire logic [3:0]  tf_addr_i,
  input  wire logic        tf_wr_i,
  input  wire logic        tf_rd_i,
  input  wire logic [7:0]  tf_wdata_i,
  output logic      [7:0]  tf_rdata_o,
  output logic             intrq_o,
  // card state
  input  wire logic        drive_id_i,
  input  wire logic        pwr_standby_i,
  // status view
  output logic             busy_o,
  output logic             drq_o,
  // media engine
  output logic             med_go_o,
  output logic      [7:0]  med_op_o,
  output logic      [1:0]  med_class_o,
  output logic      [7:0]  med_count_o,
  output logic      [7:0]  med_sector_o,
  output logic      [15:0] med_cyl_o,
  output logic      [3:0]  med_head_o,
  output logic             med_lba_o,
  input  wire logic        med_buf_ready_i,
  input  wire logic        med_done_i,
  input  wire logic        med_fault_i,
  input  wire logic        med_error_i
);
  if (DRQ2_CYC < 1 || DRQ2_CYC >= (1 << tfci_pkg::TMR_W) ||
      DRQ3_CYC < 1 || DRQ3_CYC >= (1 << tfci_pkg::TMR_W)) begin : g_bad_cfg
    // timer too narrow for the chosen prep timeout
    $error("prep timeout does not fit the timer");
  end

  //////////////////////////////////////////////////////////////////////////
  // state
  logic [7:0]           feat_q;
  logic [7:0]           sec_cnt_q;
  logic [7:0]           sec_num_q;
  logic [15:0]          cyl_q;
  logic [7:0]           drv_head_q;
  logic                 nien_q;
  logic                 srst_q;
  logic                 rdy_q;
  logic                 busy_q;
  logic                 drq_q;
  logic                 err_q;
  logic                 abrt_q;
  logic                 dwf_q;
  logic                 pend_q;
  logic [7:0]           rdata_q;
  logic [tfci_pkg::TMR_W-1:0] tmr_q;
  tfci_pkg::tfci_state_t      state_q;
  tfci_pkg::tfci_kind_t       kind_q;
  tfci_pkg::tfci_kind_t       dec_kind;
  logic [1:0]           dec_class;
  logic                 dec_dh_full;
  logic                 blk_rst;
  logic                 tf_write;
  logic                 cmd_take;
  logic                 finish;
  logic                 wr_busy;
  logic [tfci_pkg::TMR_W-1:0] tmr_lim;

  function automatic logic is_wr(input logic [3:0] ofs);
    is_wr = tf_wr_i && tf_addr_i == ofs;
  endfunction

  function automatic logic [7:0] status_byte();
    status_byte = {busy_q, rdy_q, dwf_q, rdy_q, drq_q, 1'b0, 1'b0, err_q};
  endfunction

  tfci_cmd_decode u_dec (
    .opcode_i  (tf_wdata_i),
    .kind_o    (dec_kind),
    .class_o   (dec_class),
    .dh_full_o (dec_dh_full)
  );

  //////////////////////////////////////////////////////////////////////////
  // command acceptance
  assign blk_rst  = !rst_n_i || srst_q;
  assign tf_write = !busy_q && !srst_q;
  assign cmd_take = is_wr(tfci_pkg::OFS_CMD_STAT) && tf_write;
  assign finish   = state_q == tfci_pkg::ST_QUICK ||
                    (state_q == tfci_pkg::ST_EXEC && med_done_i) ||
                    (state_q == tfci_pkg::ST_XFER && med_done_i) ||
                    (state_q == tfci_pkg::ST_PREP && !med_buf_ready_i &&
                     tmr_q == tmr_lim);
  assign wr_busy  = state_q == tfci_pkg::ST_XFER ||
                    (state_q == tfci_pkg::ST_EXEC &&
                     kind_q == tfci_pkg::K_ERASE);
  assign tmr_lim  = med_class_o == 2'h3 ?
                    tfci_pkg::TMR_W'(DRQ3_CYC) :
                    tfci_pkg::TMR_W'(DRQ2_CYC);

  //////////////////////////////////////////////////////////////////////////
  // device control, writable while busy
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      srst_q <= 1'b0;
      nien_q <= 1'b0;
    end else if (is_wr(tfci_pkg::OFS_CTL_ALT)) begin
      srst_q <= tf_wdata_i[tfci_pkg::CTL_SRST];
      nien_q <= tf_wdata_i[tfci_pkg::CTL_NIEN];
    end
  end

  always_ff @(posedge clk_i) begin
    if (blk_rst) begin
      rdy_q <= 1'b0;
    end else begin
      rdy_q <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // parameter registers
  always_ff @(posedge clk_i) begin
    if (blk_rst) begin
      feat_q     <= '0;
      sec_num_q  <= '0;
      cyl_q      <= '0;
      drv_head_q <= tfci_pkg::DH_RESET;
    end else if (tf_write && tf_wr_i) begin
      case (tf_addr_i)
        tfci_pkg::OFS_ERR_FEAT: feat_q <= tf_wdata_i;
        tfci_pkg::OFS_SEC_NUM:  sec_num_q <= tf_wdata_i;
        tfci_pkg::OFS_CYL_LO:   cyl_q[7:0] <= tf_wdata_i;
        tfci_pkg::OFS_CYL_HI:   cyl_q[15:8] <= tf_wdata_i;
        tfci_pkg::OFS_DRV_HEAD: drv_head_q <= tf_wdata_i;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (blk_rst) begin
      sec_cnt_q <= tfci_pkg::SC_RESET;
    end else if (state_q == tfci_pkg::ST_QUICK &&
                 kind_q == tfci_pkg::K_PWRQ) begin
      sec_cnt_q <= pwr_standby_i ? tfci_pkg::SC_STANDBY
                                 : tfci_pkg::SC_IDLE;
    end else if (tf_write && is_wr(tfci_pkg::OFS_SEC_CNT)) begin
      sec_cnt_q <= tf_wdata_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // command sequencer
  always_ff @(posedge clk_i) begin
    if (blk_rst) begin
      state_q <= tfci_pkg::ST_IDLE;
      kind_q  <= tfci_pkg::K_NOP;
      busy_q  <= 1'b0;
      drq_q   <= 1'b0;
      err_q   <= 1'b0;
      abrt_q  <= 1'b0;
      dwf_q   <= 1'b0;
      tmr_q   <= '0;
    end else begin
      case (state_q)
        tfci_pkg::ST_IDLE: begin
          if (cmd_take) begin
            busy_q <= 1'b1;
            drq_q  <= 1'b0;
            err_q  <= 1'b0;
            abrt_q <= 1'b0;
            dwf_q  <= 1'b0;
            kind_q <= dec_kind;
            tmr_q  <= '0;
            if (dec_kind != tfci_pkg::K_MEDIA &&
                dec_kind != tfci_pkg::K_ERASE) begin
              state_q <= tfci_pkg::ST_QUICK;
            end else if (dec_class == 2'h1) begin
              state_q <= tfci_pkg::ST_EXEC;
            end else begin
              state_q <= tfci_pkg::ST_PREP;
            end
          end
        end
        tfci_pkg::ST_QUICK: begin
          busy_q  <= 1'b0;
          err_q   <= kind_q == tfci_pkg::K_BAD;
          abrt_q  <= kind_q == tfci_pkg::K_BAD;
          state_q <= tfci_pkg::ST_IDLE;
        end
        tfci_pkg::ST_EXEC: begin
          if (med_done_i) begin
            busy_q  <= 1'b0;
            dwf_q   <= med_fault_i;
            err_q   <= med_fault_i || med_error_i;
            state_q <= tfci_pkg::ST_IDLE;
          end
        end
        tfci_pkg::ST_PREP: begin
          tmr_q <= tmr_q + 1'b1;
          if (med_buf_ready_i) begin
            drq_q   <= 1'b1;
            busy_q  <= 1'b0;
            state_q <= tfci_pkg::ST_XFER;
          end else if (tmr_q == tmr_lim) begin
            busy_q  <= 1'b0;
            err_q   <= 1'b1;
            abrt_q  <= 1'b1;
            state_q <= tfci_pkg::ST_IDLE;
          end
        end
        tfci_pkg::ST_XFER: begin
          if (med_done_i) begin
            drq_q   <= 1'b0;
            dwf_q   <= med_fault_i;
            err_q   <= med_fault_i || med_error_i;
            state_q <= tfci_pkg::ST_IDLE;
          end
        end
        default: begin
          busy_q  <= 1'b0;
          state_q <= tfci_pkg::ST_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // media command launch
  always_ff @(posedge clk_i) begin
    if (blk_rst) begin
      med_go_o     <= 1'b0;
      med_op_o     <= '0;
      med_class_o  <= 2'h1;
      med_count_o  <= '0;
      med_sector_o <= '0;
      med_cyl_o    <= '0;
      med_head_o   <= '0;
      med_lba_o    <= 1'b0;
    end else begin
      med_go_o <= cmd_take && (dec_kind == tfci_pkg::K_MEDIA ||
                               dec_kind == tfci_pkg::K_ERASE);
      if (cmd_take) begin
        med_op_o     <= tf_wdata_i;
        med_class_o  <= dec_class;
        med_count_o  <= sec_cnt_q;
        med_sector_o <= sec_num_q;
        med_cyl_o    <= cyl_q;
        med_head_o   <= dec_dh_full ? drv_head_q[3:0] : '0;
        med_lba_o    <= dec_dh_full & drv_head_q[tfci_pkg::DH_LBA_BIT];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // interrupt pending, a new event wins over a status read
  always_ff @(posedge clk_i) begin
    if (blk_rst) begin
      pend_q <= 1'b0;
    end else if (finish) begin
      pend_q <= 1'b1;
    end else if (tf_rd_i && tf_addr_i == tfci_pkg::OFS_CMD_STAT) begin
      pend_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read data
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_q <= '0;
    end else if (tf_rd_i) begin
      case (tf_addr_i)
        tfci_pkg::OFS_ERR_FEAT: rdata_q <= {5'h00, abrt_q, 2'h0};
        tfci_pkg::OFS_SEC_CNT:  rdata_q <= sec_cnt_q;
        tfci_pkg::OFS_SEC_NUM:  rdata_q <= sec_num_q;
        tfci_pkg::OFS_CYL_LO:   rdata_q <= cyl_q[7:0];
        tfci_pkg::OFS_CYL_HI:   rdata_q <= cyl_q[15:8];
        tfci_pkg::OFS_DRV_HEAD: rdata_q <= drv_head_q;
        tfci_pkg::OFS_CMD_STAT: rdata_q <= status_byte();
        tfci_pkg::OFS_CTL_ALT:  rdata_q <= status_byte();
        tfci_pkg::OFS_DRV_ADDR: begin
          rdata_q <= {1'b0,
                      !wr_busy,
                      ~drv_head_q[3:0],
                      !(rdy_q && drv_head_q[tfci_pkg::DH_DRV_BIT] &&
                        drive_id_i),
                      !(rdy_q && !drv_head_q[tfci_pkg::DH_DRV_BIT] &&
                        !drive_id_i)};
        end
        default: rdata_q <= '0;
      endcase
    end
  end

  assign tf_rdata_o = rdata_q;
  assign intrq_o    = pend_q && !nien_q;
  assign busy_o     = busy_q;
  assign drq_o      = drq_q;

  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (blk_rst);

  logic rd_addr_q;
  always_ff @(posedge clk_i) begin
    rd_addr_q <= tf_rd_i && tf_addr_i == tfci_pkg::OFS_DRV_ADDR;
  end

  sequence s_quick_take;
    cmd_take && dec_kind != tfci_pkg::K_MEDIA &&
    dec_kind != tfci_pkg::K_ERASE;
  endsequence

  sequence s_quick_end(logic [7:0] sc);
    busy_q ##1 (!busy_q && sec_cnt_q == sc && pend_q);
  endsequence

  a_busy_on_cmd: assert property (
    cmd_take |=> busy_q || drq_q)
    else $error("busy not set after command write");
  a_drq_busy_drop: assert property (
    $rose(drq_q) |-> !busy_q && $past(busy_q))
    else $error("busy not dropped with data request");
  a_prep_bound: assert property (
    state_q == tfci_pkg::ST_PREP |-> tmr_q <= tmr_lim)
    else $error("prep wait ran past its limit");
  a_wgate_level: assert property (
    rd_addr_q && $past(wr_busy) |-> !tf_rdata_o[6])
    else $error("write gate high during write");
  a_head_invert: assert property (
    rd_addr_q |-> tf_rdata_o[5:2] == ~$past(drv_head_q[3:0]))
    else $error("head readback not inverted");
  a_drv1_sel: assert property (
    rd_addr_q |-> tf_rdata_o[1] ==
      !$past(rdy_q && drv_head_q[tfci_pkg::DH_DRV_BIT] && drive_id_i))
    else $error("drive one select readback wrong");
  a_drv0_sel: assert property (
    rd_addr_q |-> tf_rdata_o[0] ==
      !$past(rdy_q && !drv_head_q[tfci_pkg::DH_DRV_BIT] && !drive_id_i))
    else $error("drive zero select readback wrong");
  a_nop_no_media: assert property (
    s_quick_take |=> !med_go_o [*2])
    else $error("media launched for quick command");
  a_pwr_standby: assert property (
    cmd_take && dec_kind == tfci_pkg::K_PWRQ ##1 pwr_standby_i
    |-> s_quick_end(tfci_pkg::SC_STANDBY))
    else $error("standby power query answer wrong");
  a_pwr_idle: assert property (
    cmd_take && dec_kind == tfci_pkg::K_PWRQ ##1 !pwr_standby_i
    |-> s_quick_end(tfci_pkg::SC_IDLE))
    else $error("idle power query answer wrong");
  a_dh_drive_only: assert property (
    cmd_take && !dec_dh_full |=> med_head_o == '0 && !med_lba_o)
    else $error("head bits passed for drive-only command");
  a_bad_abort: assert property (
    cmd_take && dec_kind == tfci_pkg::K_BAD |=> busy_q ##1
    (!busy_q && err_q && abrt_q && !med_go_o))
    else $error("unsupported opcode not aborted");
  a_stat_read_clr: assert property (
    tf_rd_i && tf_addr_i == tfci_pkg::OFS_CMD_STAT && !finish |=> !pend_q)
    else $error("status read left interrupt pending");
  a_alt_read_keep: assert property (
    tf_rd_i && tf_addr_i == tfci_pkg::OFS_CTL_ALT && pend_q |=> pend_q)
    else $error("alternate status read cleared interrupt");
  a_erase_no_drq: assert property (
    state_q == tfci_pkg::ST_EXEC |-> !drq_q)
    else $error("data request during class one command");
endmodule
`default_nettype wire

// ### tfci_media_model.sv
`timescale 1ns/100ps
`default_nettype none
module tfci_media_model #(
  parameter int BUF_LAT  = 5,
  parameter int DONE_LAT = 8
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // launch
  input  wire logic       med_go_i,
  input  wire logic [1:0] med_class_i,
  input  wire logic       fault_en_i,
  // answer
  output logic            buf_ready_o,
  output logic            done_o,
  output logic            fault_o,
  output logic            error_o
);
  logic       act_q;
  logic       run_q;
  logic       tog_q;
  logic [7:0] cnt_q;
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i) begin
    buf_ready_o <= 1'b0;
    done_o      <= 1'b0;
    tog_q       <= ~tog_q;
    if (!rst_n_i) begin
      act_q <= 1'b0;
      tog_q <= 1'b0;
    end else if (med_go_i) begin
      act_q <= 1'b1;
      run_q <= (med_class_i < 2'h2);
      cnt_q <= 8'h00;
    end else if (act_q) begin
      cnt_q <= cnt_q + 8'h01;
      if (!run_q && cnt_q == 8'(BUF_LAT)) begin
        buf_ready_o <= 1'b1;
        run_q       <= 1'b1;
        cnt_q       <= 8'h00;
      end
      if (run_q && cnt_q == 8'(DONE_LAT)) begin
        done_o <= 1'b1;
        act_q  <= 1'b0;
      end
    end
  end
  // qualifiers only mean something beside done
  assign fault_o = done_o ? fault_en_i : tog_q;
  assign error_o = done_o ? 1'b0 : ~tog_q;
endmodule
`default_nettype wire

// ### ata_task_file_command_intake_bench.sv
`timescale 1ns/100ps
`default_nettype none
module ata_task_file_command_intake_bench;
  logic        clk_i, rst_n_i, tf_wr_i, tf_rd_i, intrq_o, busy_o, drq_o;
  logic        drive_id_i, pwr_standby_i, med_go_o, med_lba_o, fault_en;
  logic        buf_rdy, med_done, med_fault, med_err, drq_hit;
  logic [3:0]  tf_addr_i, med_head_o;
  logic [7:0]  tf_wdata_i, tf_rdata_o, med_op_o, med_count_o, med_sector_o;
  logic [1:0]  med_class_o;
  logic [15:0] med_cyl_o;
  int          mismatches, n_tests;
  localparam logic [7:0] QOP [4] = '{8'h00, 8'h98, 8'hE5, 8'hFF};
  localparam logic [7:0] QSC [4] = '{8'h03, 8'hFF, 8'h00, 8'h00};
  localparam logic [7:0] MOP [4] = '{8'hCD, 8'hF8, 8'hF9, 8'h38};
  localparam logic [1:0] MCL [4] = '{2'h3, 2'h1, 2'h1, 2'h2};
  localparam logic [3:0] MHD [4] = '{4'h5, 4'h0, 4'h5, 4'h5};
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  tfci_core #(.DRQ2_CYC(20), .DRQ3_CYC(40)) dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .tf_addr_i(tf_addr_i),
    .tf_wr_i(tf_wr_i), .tf_rd_i(tf_rd_i), .tf_wdata_i(tf_wdata_i),
    .tf_rdata_o(tf_rdata_o), .intrq_o(intrq_o), .drive_id_i(drive_id_i),
    .pwr_standby_i(pwr_standby_i), .busy_o(busy_o), .drq_o(drq_o),
    .med_go_o(med_go_o), .med_op_o(med_op_o), .med_class_o(med_class_o),
    .med_count_o(med_count_o), .med_sector_o(med_sector_o),
    .med_cyl_o(med_cyl_o), .med_head_o(med_head_o), .med_lba_o(med_lba_o),
    .med_buf_ready_i(buf_rdy), .med_done_i(med_done),
    .med_fault_i(med_fault), .med_error_i(med_err));
  tfci_media_model mdl (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .med_go_i(med_go_o),
    .med_class_i(med_class_o), .fault_en_i(fault_en),
    .buf_ready_o(buf_rdy), .done_o(med_done), .fault_o(med_fault),
    .error_o(med_err));
  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tick;
    @(posedge clk_i);
    #1;
  endtask
  // strobe gets a low cycle before each access
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    tick;
    tf_addr_i  = a;
    tf_wdata_i = d;
    tf_wr_i    = 1'b1;
    tick;
    tf_wr_i = 1'b0;
  endtask
  task automatic rd(input string n, input logic [3:0] a, input logic [7:0] e,
                    input logic [7:0] m);
    tick;
    tf_addr_i = a;
    tf_rd_i   = 1'b1;
    tick;
    tf_rd_i = 1'b0;
    chk(n, e & m, tf_rdata_o & m);
  endtask
  task automatic settle(input bit on_drq);
    for (int i = 0; i < 300; i++) begin
      if ((on_drq ? drq_o : busy_o) === 1'b0) break;
      tick;
      drq_hit |= (drq_o === 1'b1);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    mismatches++;
    complete_run;
  end
  initial begin
    {tf_addr_i, tf_wr_i, tf_rd_i, tf_wdata_i} = '0;
    {drive_id_i, pwr_standby_i, fault_en, drq_hit, rst_n_i} = '0;
    repeat (5) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    rd("sc_reset", 4'h2, 8'h01, 8'hFF);
    rd("dh_reset", 4'h6, 8'hA0, 8'hFF);
    rd("daddr_reset", 4'hF, 8'h7E, 8'h7F);
    wr(4'hE, 8'h00);
    wr(4'h2, 8'h03);
    wr(4'hE, 8'h04);
    wr(4'h2, 8'h55);
    wr(4'hE, 8'h00);
    rd("sc_softrst", 4'h2, 8'h01, 8'hFF);
    wr(4'h2, 8'h03);
    wr(4'h3, 8'h11);
    wr(4'h4, 8'h22);
    wr(4'h5, 8'h33);
    wr(4'h6, 8'hE5);
    rd("daddr_head", 4'hF, 8'h6A, 8'h7F);
    for (int i = 0; i < 4; i++) begin
      pwr_standby_i = (i == 2);
      wr(4'h7, QOP[i]);
      chk("quick_busy", 1'b1, busy_o);
      chk("quick_go", 1'b0, med_go_o);
      tick;
      chk("quick_done", 1'b0, busy_o);
      chk("quick_irq", 1'b1, intrq_o);
      rd("alt", 4'hE, {7'h20, i == 3}, 8'hC9);
      chk("alt_keeps", 1'b1, intrq_o);
      rd("stat", 4'h7, {7'h20, i == 3}, 8'hC9);
      chk("stat_clears", 1'b0, intrq_o);
      rd("sc_quick", 4'h2, QSC[i], 8'hFF);
      rd("err_abort", 4'h1, {5'h00, i == 3, 2'h0}, 8'h04);
    end
    wr(4'h2, 8'h03);
    for (int i = 0; i < 4; i++) begin
      wr(4'h7, MOP[i]);
      chk("med_busy", 1'b1, busy_o);
      chk("med_go", 1'b1, med_go_o);
      chk("med_op", MOP[i], med_op_o);
      chk("med_class", MCL[i], med_class_o);
      chk("med_head", MHD[i], med_head_o);
      chk("med_lba", MHD[i] != 4'h0, med_lba_o);
      chk("med_addr", 16'h3322, med_cyl_o);
      chk("med_cnt", 16'h0311, {med_count_o, med_sector_o});
      settle(1'b0);
      if (MCL[i] >= 2'h2) begin
        chk("drq_at_bsy_drop", 1'b1, drq_o);
        rd("wgate_low", 4'hF, 8'h00, 8'h40);
      end
      settle(1'b1);
      tick;
      chk("med_irq", 1'b1, intrq_o);
      rd("wgate_high", 4'hF, 8'h40, 8'h40);
      rd("med_stat", 4'h7, 8'h50, 8'hC9);
    end
    fault_en = 1'b1;
    drq_hit  = 1'b0;
    wr(4'h7, 8'hC0);
    chk("erase_go", {1'b1, 2'h1}, {med_go_o, med_class_o});
    wr(4'h2, 8'hAA);
    settle(1'b0);
    chk("erase_no_drq", 1'b0, drq_hit);
    tick;
    rd("erase_dwf", 4'h7, 8'h20, 8'h28);
    rd("sc_refused", 4'h2, 8'h03, 8'hFF);
    fault_en   = 1'b0;
    drive_id_i = 1'b1;
    wr(4'h6, 8'hF5);
    rd("daddr_drv1", 4'hF, 8'h69, 8'h7F);
    complete_run;
  end
endmodule
`default_nettype wire
